// >>> swd_map.vh
// Address map, reset values and encodings of the slave watchdog block.
// Included by every design file of the block; holds definitions only.
`ifndef SWD_MAP_VH
`define SWD_MAP_VH

// Register offsets on the register access port
`define SWD_ADR_PRESC      16'h0400
`define SWD_ADR_LPI_CNT    16'h0410
`define SWD_ADR_BUS_CNT    16'h0420

// Register reset values (prescaler 2498, count 1000 -> 100 ms)
`define SWD_RST_PRESC      16'h09c2
`define SWD_RST_LPI_CNT    16'h03e8
`define SWD_RST_BUS_CNT    16'h03e8

// Register and data widths
`define SWD_RW             16
`define SWD_DW             8

// Base tick and system clock period in ns (25 MHz, 10 MHz)
`define SWD_BASE_TICK_NS   40
`define SWD_CLK_NS         100
// Base ticks added to the prescaler value for one watchdog tick
`define SWD_PRESC_ADD      17'h00002

// Slave state codes
`define SWD_ST_INIT        4'h1
`define SWD_ST_PREOP       4'h2
`define SWD_ST_BOOT        4'h3
`define SWD_ST_SAFEOP      4'h4
`define SWD_ST_OP          4'h8

`endif

// >>> swd_tick_gen.v
// Watchdog tick generator: turns the system clock into ticks of
// (prescaler + 2) base ticks of 40 ns each.
// Assumes a 10 MHz clock; several base ticks elapse per clock edge.
`timescale 1ns/1ps
`include "swd_map.vh"

module swd_tick_gen (
	clock,
	rst,
	presc,
	tick
);
	input  wire                clock;
	input  wire                rst;
	input  wire [`SWD_RW-1:0]  presc;
	output reg                 tick;

	localparam [7:0] BASE_NS = `SWD_BASE_TICK_NS;
	localparam [7:0] CLK_NS  = `SWD_CLK_NS;

	reg  [7:0]  frac_r;       // Leftover ns below one base tick
	reg  [16:0] base_cnt_r;   // Base ticks inside current watchdog tick
	reg  [7:0]  frac_sum;
	reg  [7:0]  base_add;
	reg  [16:0] tick_len;
	reg  [16:0] cnt_sum;

	// Base ticks elapsed this clock; the fraction is carried so the
	// 2.5 base ticks per clock average out exactly
	always @* begin
		frac_sum = frac_r + CLK_NS;
		base_add = frac_sum / BASE_NS;
		tick_len = {1'b0, presc} + `SWD_PRESC_ADD;
		cnt_sum  = base_cnt_r + {9'h000, base_add};
	end

	// Watchdog tick when the base count reaches or passes the tick length
	always @(posedge clock) begin
		if (rst) begin
			frac_r     <= 8'h00;
			base_cnt_r <= 17'h00000;
			tick       <= 1'b0;
		end else begin
			frac_r <= frac_sum % BASE_NS;
			if (cnt_sum >= tick_len) begin
				base_cnt_r <= cnt_sum - tick_len;
				tick       <= 1'b1;
			end else begin
				base_cnt_r <= cnt_sum;
				tick       <= 1'b0;
			end
		end
	end

endmodule

// >>> swd_slave_ctrl.v
// Fieldbus slave control: two timeout watchdogs sharing one tick
// prescaler, the slave state machine and the output safe-state gate.
// Assumes all strobes and inputs come from logic on the same clock;
// the master reaches the registers through the register access port.
`timescale 1ns/1ps
`include "swd_map.vh"

module swd_slave_ctrl (
	clock,
	rst,
	reg_wr,
	reg_rd,
	reg_addr,
	reg_wdata,
	reg_rdata,
	pd_exchange_ok,
	lpi_access,
	state_req_valid,
	state_req,
	mbx_cfg_ok,
	pd_cfg_ok,
	sync_cfg_ok,
	err_ack,
	master_out,
	safe_value,
	in_data,
	state,
	state_err,
	mbx_en,
	file_xfer_only,
	pd_en,
	bus_trip,
	lpi_trip,
	out_data,
	in_image
);
	input  wire                clock;
	input  wire                rst;
	input  wire                reg_wr;
	input  wire                reg_rd;
	input  wire [15:0]         reg_addr;
	input  wire [`SWD_RW-1:0]  reg_wdata;
	output reg  [`SWD_RW-1:0]  reg_rdata;
	input  wire                pd_exchange_ok;
	input  wire                lpi_access;
	input  wire                state_req_valid;
	input  wire [3:0]          state_req;
	input  wire                mbx_cfg_ok;
	input  wire                pd_cfg_ok;
	input  wire                sync_cfg_ok;
	input  wire                err_ack;
	input  wire [`SWD_DW-1:0]  master_out;
	input  wire [`SWD_DW-1:0]  safe_value;
	input  wire [`SWD_DW-1:0]  in_data;
	output reg  [3:0]          state;
	output reg                 state_err;
	output reg                 mbx_en;
	output reg                 file_xfer_only;
	output reg                 pd_en;
	output reg                 bus_trip;
	output reg                 lpi_trip;
	output reg  [`SWD_DW-1:0]  out_data;
	output reg  [`SWD_DW-1:0]  in_image;

	localparam [3:0] ST_INIT   = `SWD_ST_INIT;
	localparam [3:0] ST_PREOP  = `SWD_ST_PREOP;
	localparam [3:0] ST_BOOT   = `SWD_ST_BOOT;
	localparam [3:0] ST_SAFEOP = `SWD_ST_SAFEOP;
	localparam [3:0] ST_OP     = `SWD_ST_OP;

	// Register file
	reg  [`SWD_RW-1:0] presc_r;
	reg  [`SWD_RW-1:0] lpi_cnt_r;
	reg  [`SWD_RW-1:0] bus_cnt_r;

	// Watchdog elapsed-tick counters
	reg  [`SWD_RW-1:0] bus_el_r;
	reg  [`SWD_RW-1:0] lpi_el_r;

	// State machine next values
	reg  [3:0]         state_nxt;
	reg                err_nxt;
	reg                copy_in;
	reg                trans_ok;

	wire               wd_tick;
	wire               bus_wd_on;
	wire               lpi_wd_on;
	wire               bus_expire;
	wire               lpi_expire;
	wire               out_live;

	// Next elapsed count: restart, saturating step, or hold
	function [`SWD_RW-1:0] wd_elapsed;
		input [`SWD_RW-1:0] el;
		input               restart;
		input               step;
		begin
			if (restart)
				wd_elapsed = {`SWD_RW{1'b0}};
			else if (step && el != {`SWD_RW{1'b1}})
				wd_elapsed = el + 16'h0001;
			else
				wd_elapsed = el;
		end
	endfunction

	// Timeout reached: running, not restarted, elapsed meets the count
	function wd_expired;
		input [`SWD_RW-1:0] el;
		input [`SWD_RW-1:0] cnt;
		input               on;
		input               restart;
		begin
			wd_expired = on && !restart && (el >= cnt);
		end
	endfunction

	// Shared watchdog tick from the single prescaler
	swd_tick_gen u_tick (
		.clock (clock),
		.rst   (rst),
		.presc (presc_r),
		.tick  (wd_tick)
	);

	// A zero count disables the watchdog entirely
	assign bus_wd_on  = (bus_cnt_r != {`SWD_RW{1'b0}});
	assign lpi_wd_on  = (lpi_cnt_r != {`SWD_RW{1'b0}});
	assign bus_expire = wd_expired(bus_el_r, bus_cnt_r, bus_wd_on,
		pd_exchange_ok);
	assign lpi_expire = wd_expired(lpi_el_r, lpi_cnt_r, lpi_wd_on,
		lpi_access);

	// Register writes; unwritten settings simply keep their value,
	// so a master that skips a disabled setting changes nothing
	always @(posedge clock) begin
		if (rst) begin
			presc_r   <= `SWD_RST_PRESC;
			lpi_cnt_r <= `SWD_RST_LPI_CNT;
			bus_cnt_r <= `SWD_RST_BUS_CNT;
		end else if (reg_wr) begin
			if (reg_addr == `SWD_ADR_PRESC)
				presc_r <= reg_wdata;
			else if (reg_addr == `SWD_ADR_LPI_CNT)
				lpi_cnt_r <= reg_wdata;
			else if (reg_addr == `SWD_ADR_BUS_CNT)
				bus_cnt_r <= reg_wdata;
		end
	end

	// Registered read data; unmapped offsets read as zero
	always @(posedge clock) begin
		if (rst) begin
			reg_rdata <= {`SWD_RW{1'b0}};
		end else if (reg_rd) begin
			if (reg_addr == `SWD_ADR_PRESC)
				reg_rdata <= presc_r;
			else if (reg_addr == `SWD_ADR_LPI_CNT)
				reg_rdata <= lpi_cnt_r;
			else if (reg_addr == `SWD_ADR_BUS_CNT)
				reg_rdata <= bus_cnt_r;
			else
				reg_rdata <= {`SWD_RW{1'b0}};
		end
	end

	// Elapsed-tick counters; a restart clears only the elapsed count, not
	// the shared partial tick, so the first timeout may run up to one tick short
	always @(posedge clock) begin
		if (rst) begin
			bus_el_r <= {`SWD_RW{1'b0}};
			lpi_el_r <= {`SWD_RW{1'b0}};
		end else begin
			bus_el_r <= wd_elapsed(bus_el_r, pd_exchange_ok,
				wd_tick);
			lpi_el_r <= wd_elapsed(lpi_el_r, lpi_access,
				wd_tick);
		end
	end

	// Trip flags: the bus trip clears on a good data access or a zero count,
	// and leaves the slave state untouched
	always @(posedge clock) begin
		if (rst) begin
			bus_trip <= 1'b0;
			lpi_trip <= 1'b0;
		end else begin
			if (!bus_wd_on || pd_exchange_ok)
				bus_trip <= 1'b0;
			else if (bus_expire)
				bus_trip <= 1'b1;
			if (!lpi_wd_on || lpi_access)
				lpi_trip <= 1'b0;
			else if (lpi_expire)
				lpi_trip <= 1'b1;
		end
	end

	// Checks each requested change against the current state
	always @* begin
		state_nxt = state;
		err_nxt   = state_err;
		copy_in   = 1'b0;
		trans_ok  = 1'b0;
		if (state_req_valid && state_req != state) begin
			case (state)
			ST_INIT: begin
				// Init leaves only after mailbox channels check out
				if ((state_req == ST_PREOP || state_req == ST_BOOT)
					&& mbx_cfg_ok)
					trans_ok = 1'b1;
			end
			ST_PREOP: begin
				if (state_req == ST_INIT)
					trans_ok = 1'b1;
				else if (state_req == ST_SAFEOP && pd_cfg_ok
					&& sync_cfg_ok) begin
					trans_ok = 1'b1;
					copy_in  = 1'b1;
				end
			end
			ST_SAFEOP: begin
				if (state_req == ST_INIT || state_req == ST_PREOP
					|| state_req == ST_OP)
					trans_ok = 1'b1;
			end
			ST_OP: begin
				if (state_req == ST_INIT || state_req == ST_PREOP
					|| state_req == ST_SAFEOP)
					trans_ok = 1'b1;
			end
			ST_BOOT: begin
				// Boot returns to init and nowhere else
				if (state_req == ST_INIT)
					trans_ok = 1'b1;
			end
			default: begin
				trans_ok = 1'b0;
			end
			endcase
			if (trans_ok)
				state_nxt = state_req;
			else
				err_nxt = 1'b1;
		end
		// A new failure in the acknowledge cycle keeps the flag set
		if (err_ack && !(state_req_valid && state_req != state
			&& !trans_ok))
			err_nxt = 1'b0;
	end

	// State register; the new state is the acknowledge to the master
	always @(posedge clock) begin
		if (rst) begin
			state     <= ST_INIT;
			state_err <= 1'b0;
		end else begin
			state     <= state_nxt;
			state_err <= err_nxt;
		end
	end

	// Communication permissions per state, registered with the state
	always @(posedge clock) begin
		if (rst) begin
			mbx_en         <= 1'b0;
			pd_en          <= 1'b0;
			file_xfer_only <= 1'b0;
		end else begin
			case (state_nxt)
			ST_PREOP: begin
				mbx_en         <= 1'b1;
				pd_en          <= 1'b0;
				file_xfer_only <= 1'b0;
			end
			ST_SAFEOP, ST_OP: begin
				mbx_en         <= 1'b1;
				pd_en          <= 1'b1;
				file_xfer_only <= 1'b0;
			end
			ST_BOOT: begin
				mbx_en         <= 1'b1;
				pd_en          <= 1'b0;
				file_xfer_only <= 1'b1;
			end
			default: begin
				mbx_en         <= 1'b0;
				pd_en          <= 1'b0;
				file_xfer_only <= 1'b0;
			end
			endcase
		end
	end

	// Input image: copied on the safe_operational_state entry in the same edge as the
	// state change, then refreshed every cycle in safe_operational_state and op
	always @(posedge clock) begin
		if (rst)
			in_image <= {`SWD_DW{1'b0}};
		else if (copy_in || state == ST_SAFEOP || state == ST_OP)
			in_image <= in_data;
	end

	// Outputs follow the master only in op, or in safe_operational_state when the
	// bus watchdog is off; any trip forces the safe value. Validity
	// of master_out before op is left to the master.
	assign out_live = (state == ST_OP)
		|| (state == ST_SAFEOP && !bus_wd_on);

	always @(posedge clock) begin
		if (rst)
			out_data <= {`SWD_DW{1'b0}};
		else if (bus_trip || lpi_trip || !out_live)
			out_data <= safe_value;
		else
			out_data <= master_out;
	end

endmodule

// >>> swd_peer_model.sv
// Far-side model: bus master process data and local processor accesses.
// Assumes the same clock as the block; pulses are one cycle wide.
`timescale 1ns/1ps

module swd_peer_model (
	input  wire logic clock,
	input  wire logic pd_on,
	input  wire logic lpi_on,
	output logic      pd_exchange_ok = 1'b0,
	output logic      lpi_access = 1'b0
);
	logic ph = 1'b0;

	// Both peers pulse every other cycle while enabled
	always @(posedge clock) begin
		ph <= ~ph;
		pd_exchange_ok <= pd_on & ph;
		lpi_access <= lpi_on & ph;
	end
endmodule

// >>> swd_slave_ctrl_sva.sv
// Checker for the slave watchdog block, bound to its top module.
// Sees only top-level ports; state codes come from the block's map.
`timescale 1ns/1ps
`include "swd_map.vh"

module swd_slave_ctrl_sva (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_rdata,
	input wire logic        pd_exchange_ok,
	input wire logic        state_req_valid,
	input wire logic [3:0]  state_req,
	input wire logic        mbx_cfg_ok,
	input wire logic [7:0]  master_out,
	input wire logic [7:0]  safe_value,
	input wire logic [3:0]  state,
	input wire logic        state_err,
	input wire logic        mbx_en,
	input wire logic        pd_en,
	input wire logic        bus_trip,
	input wire logic        lpi_trip,
	input wire logic [7:0]  out_data
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Either watchdog tripped
	wire trip = bus_trip | lpi_trip;

	a_init_quiet: assert property (
		state == `SWD_ST_INIT |-> !mbx_en && !pd_en) else $error("init traffic");
	a_pd_perm: assert property (
		pd_en |-> state == `SWD_ST_SAFEOP || state == `SWD_ST_OP)
		else $error("data in wrong state");
	a_boot_entry: assert property (
		$changed(state) && state == `SWD_ST_BOOT |-> $past(state) == `SWD_ST_INIT)
		else $error("boot not from init");
	a_trip_safe: assert property (
		$past(trip) && trip |-> out_data == $past(safe_value))
		else $error("trip not safe");
	a_op_passes: assert property (
		state == `SWD_ST_OP && $past(state) == `SWD_ST_OP && !trip && !$past(trip)
		|-> out_data == $past(master_out)) else $error("op output wrong");
	a_pd_clears: assert property (
		pd_exchange_ok |=> !bus_trip) else $error("trip not cleared");
	a_cfg_refuse: assert property (
		state_req_valid && state == `SWD_ST_INIT && state_req == `SWD_ST_PREOP
		&& !mbx_cfg_ok |=> state == `SWD_ST_INIT && state_err)
		else $error("bad config taken");
	a_no_preop_op: assert property (
		state_req_valid && state == `SWD_ST_PREOP && state_req == `SWD_ST_OP
		|=> state == `SWD_ST_PREOP && state_err) else $error("preop to op");
	a_unmapped_zero: assert property (
		reg_rd && reg_addr == 16'h0404 |=> reg_rdata == 16'h0000)
		else $error("unmapped read");

	c_op_trip: cover property (state == `SWD_ST_OP ##1 lpi_trip);
	c_bus_trip: cover property ($rose(bus_trip));
	c_boot: cover property (state == `SWD_ST_BOOT);
endmodule

bind swd_slave_ctrl swd_slave_ctrl_sva u_sva (.clock(clock), .rst(rst),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.pd_exchange_ok(pd_exchange_ok), .state_req_valid(state_req_valid),
	.state_req(state_req), .mbx_cfg_ok(mbx_cfg_ok), .master_out(master_out),
	.safe_value(safe_value), .state(state), .state_err(state_err),
	.mbx_en(mbx_en), .pd_en(pd_en), .bus_trip(bus_trip),
	.lpi_trip(lpi_trip), .out_data(out_data));

// >>> swd_slave_ctrl_tb_top.sv
// Self-checking bench for the slave watchdog block.
// Assumes a 10 MHz clock; counts are shortened by register writes.
`timescale 1ns/1ps
`include "swd_map.vh"

module swd_slave_ctrl_tb_top;
	reg        clock = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	reg [15:0] reg_addr = 0, reg_wdata = 0;
	reg        state_req_valid = 0, mbx_cfg_ok = 0, pd_cfg_ok = 0;
	reg        sync_cfg_ok = 0, err_ack = 0, pd_on = 0, lpi_on = 0;
	reg [3:0]  state_req = 0;
	reg [7:0]  master_out = 8'ha5, safe_value = 8'h5a, in_data = 8'h3c;
	wire [15:0] reg_rdata;
	wire [3:0]  state;
	wire [7:0]  out_data, in_image;
	wire        state_err, mbx_en, file_xfer_only, pd_en;
	wire        bus_trip, lpi_trip, pd_exchange_ok, lpi_access;
	integer     fails = 0, n_checks = 0, n;

	swd_slave_ctrl u_dut (.clock(clock), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .pd_exchange_ok(pd_exchange_ok),
		.lpi_access(lpi_access), .state_req_valid(state_req_valid),
		.state_req(state_req), .mbx_cfg_ok(mbx_cfg_ok), .pd_cfg_ok(pd_cfg_ok),
		.sync_cfg_ok(sync_cfg_ok), .err_ack(err_ack), .master_out(master_out),
		.safe_value(safe_value), .in_data(in_data), .state(state),
		.state_err(state_err), .mbx_en(mbx_en),
		.file_xfer_only(file_xfer_only), .pd_en(pd_en), .bus_trip(bus_trip),
		.lpi_trip(lpi_trip), .out_data(out_data), .in_image(in_image));
	swd_peer_model u_peer (.clock(clock), .pd_on(pd_on), .lpi_on(lpi_on),
		.pd_exchange_ok(pd_exchange_ok), .lpi_access(lpi_access));

	initial forever #50 clock = ~clock;

	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("wrong value t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Register write, effective after the taking edge
	task wr(input [15:0] a, input [15:0] d);
		begin
			@(posedge clock);
			reg_wr <= 1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clock);
			reg_wr <= 0;
		end
	endtask
	task rd(input [15:0] a, input [15:0] exp);
		begin
			@(posedge clock);
			reg_rd <= 1;
			reg_addr <= a;
			@(posedge clock);
			reg_rd <= 0;
			#1 chk(reg_rdata, exp);
		end
	endtask
	// State request; result checked one cycle later
	task req(input [3:0] s, input [3:0] exp, input e);
		begin
			@(posedge clock);
			state_req_valid <= 1;
			state_req <= s;
			@(posedge clock);
			state_req_valid <= 0;
			#1 chk(state, exp);
			chk(state_err, e);
			if (e) begin
				err_ack <= 1;
				@(posedge clock);
				err_ack <= 0;
				#1 chk(state_err, 0);
			end
		end
	endtask
	// Bounded wait for a trip; lo..hi cycles allowed
	task wtrip(input sel, input integer lo, input integer hi);
		begin
			n = 0;
			while (!(sel ? lpi_trip : bus_trip) && n < hi) begin
				@(posedge clock);
				#1 n = n + 1;
			end
			// A wait that runs out without a trip is a mismatch
			chk((sel ? lpi_trip : bus_trip) && n >= lo && n <= hi, 1);
		end
	endtask
	task wait_cyc(input integer c);
		begin
			repeat (c) @(posedge clock);
			#1;
		end
	endtask

	task t_regs;
		begin
			rd(16'h0400, 16'h09c2);
			rd(16'h0410, 16'h03e8);
			rd(16'h0420, 16'h03e8);
			rd(16'h0404, 16'h0000);
			wr(16'h0400, 16'h0003);
			rd(16'h0400, 16'h0003);
		end
	endtask
	// Prescaler 3 gives 200 ns ticks, so count 4 is about 8 cycles
	task t_wdog;
		begin
			pd_on <= 1;
			lpi_on <= 1;
			wr(16'h0420, 16'h0004);
			wr(16'h0410, 16'h0004);
			wait_cyc(40);
			chk(bus_trip, 0);
			chk(lpi_trip, 0);
			pd_on <= 0;
			wtrip(0, 5, 12);
			chk(state, `SWD_ST_INIT);
			pd_on <= 1;
			wait_cyc(4);
			chk(bus_trip, 0);
			lpi_on <= 0;
			wtrip(1, 5, 12);
			lpi_on <= 1;
			wr(16'h0420, 16'h0000);
			pd_on <= 0;
			wait_cyc(30);
			chk(bus_trip, 0);
		end
	endtask
	task t_states;
		begin
			chk(mbx_en | pd_en, 0);
			req(`SWD_ST_PREOP, `SWD_ST_INIT, 1);
			mbx_cfg_ok <= 1;
			req(`SWD_ST_PREOP, `SWD_ST_PREOP, 0);
			chk({mbx_en, pd_en}, 2'b10);
			req(`SWD_ST_OP, `SWD_ST_PREOP, 1);
			pd_cfg_ok <= 1;
			sync_cfg_ok <= 1;
			req(`SWD_ST_SAFEOP, `SWD_ST_SAFEOP, 0);
			chk(in_image, 8'h3c);
			wait_cyc(2);
			chk(out_data, 8'ha5);
			pd_on <= 1;
			wr(16'h0420, 16'h0004);
			wait_cyc(2);
			chk({pd_en, out_data}, 9'h15a);
			// Inputs keep refreshing while in safe_operational_state
			in_data <= 8'hc3;
			wait_cyc(2);
			chk(in_image, 8'hc3);
			req(`SWD_ST_OP, `SWD_ST_OP, 0);
			wait_cyc(2);
			chk(out_data, 8'ha5);
			lpi_on <= 0;
			wtrip(1, 5, 12);
			wait_cyc(2);
			chk(out_data, 8'h5a);
			lpi_on <= 1;
			// Bus trip in op must leave the state alone
			pd_on <= 0;
			wtrip(0, 5, 12);
			chk(state, `SWD_ST_OP);
			pd_on <= 1;
			req(`SWD_ST_INIT, `SWD_ST_INIT, 0);
			req(`SWD_ST_BOOT, `SWD_ST_BOOT, 0);
			chk({file_xfer_only, pd_en}, 2'b10);
			req(`SWD_ST_PREOP, `SWD_ST_BOOT, 1);
		end
	endtask

	task close_out;
		begin
			$display("checks %0d fails %0d", n_checks, fails);
			if (fails == 0 && n_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	// Hang limit far beyond the sequence length
	initial begin
		repeat (20000) @(posedge clock);
		fails = fails + 1;
		close_out;
	end
	initial begin
		repeat (16) @(posedge clock);
		rst <= 0;
		t_regs;
		t_wdog;
		t_states;
		close_out;
	end
endmodule
